// ### logic/t2rc_consts.svh
// register addresses, control field positions, reset values and divider counts of the reload/capture timer
// assumes an 8-bit special function register port driven by the cpu core
// Overview of operation
// RL1 - split bit clear: one 16-bit reload counter
// RL2 - 16-bit wrap reloads pair, sets high flag
// RL3 - 16-bit overflow requests interrupt when enabled
// RL4 - low enable adds interrupt on low-byte wrap
// RL5 - split bit set: two 8-bit reload timers
// RL6 - split: run bit gates high byte only
// RL7 - per-byte clock: fast select or alternate field
// RL8 - rtc/8 and comparator sources synchronised first
// RL9 - each byte wrap sets its own flag
// RL10 - split: high wrap interrupts, low when enabled
// RL11 - flags cleared only by software, never hardware
// RL12 - capture enable bit selects capture mode
// RL13 - software keeps 16-bit mode during capture
// RL14 - capture event: comparator edge or rtc/8
// RL15 - capture copies count to reload, sets flag
// RL16 - control register bit-addressable, resets to zero
// RL17 - low flag set on low wrap, every mode
// RL18 - source bit 0 rtc/8, 1 comparator edge
// RL19 - 16-bit uses low clock, gated by run
`ifndef T2RC_CONSTS_SVH
`define T2RC_CONSTS_SVH
`define T2RC_ADDR_CTRL    8'hC8
`define T2RC_ADDR_RLD_LO  8'hCA
`define T2RC_ADDR_RLD_HI  8'hCB
`define T2RC_ADDR_CNT_LO  8'hCC
`define T2RC_ADDR_CNT_HI  8'hCD
`define T2RC_CTRL_RESET   8'h00
`define T2RC_BIT_HF       7
`define T2RC_BIT_LF       6
`define T2RC_BIT_LEN      5
`define T2RC_BIT_CEN      4
`define T2RC_BIT_SPLIT    3
`define T2RC_BIT_RUN      2
`define T2RC_SYS_DIV      12
`define T2RC_RTC_DIV      8
`define T2RC_BYTE_MAX     8'hFF
`endif

// ### logic/t2rc_pkg.sv
// types shared by the reload/capture timer
// assumes t2rc_consts.svh is on the include path
package t2rc_pkg;
  // control register fields, bit 7 first
  typedef struct packed {
    logic       high_overflow_flag;
    logic       low_overflow_flag;
    logic       low_overflow_irq_enable;
    logic       capture_mode_enable;
    logic       split_mode_select;
    logic       run_control_bit;
    logic [1:0] alt_clock_field;
  } t2rc_ctrl_t;

  // one access from the cpu core on the register port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } t2rc_sfr_req_t;
endpackage

// ### logic/t2rc_timer.sv
// reload/capture timer: two count bytes, reload pair, control register on the sfr port
// assumes core_clock is sys_clk and every input is synchronous to it except rtc_clk and cmp0_out
`timescale 1ns/100ps
`include "t2rc_consts.svh"
module t2rc_timer import t2rc_pkg::*; #(
  parameter int SYS_DIV = `T2RC_SYS_DIV,
  parameter int RTC_DIV = `T2RC_RTC_DIV
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire t2rc_sfr_req_t sfr_req,
  input  wire logic          low_byte_fast_clock_sel,
  input  wire logic          high_byte_fast_clock_sel,
  input  wire logic          timer_irq_enable,
  input  wire logic          rtc_clk,
  input  wire logic          cmp0_out,
  output logic [7:0]         sfr_rdata,
  output logic               irq_request
);
  // picks the tick of one byte from its fast select and the alternate field
  function automatic logic src_tick(input logic fast, input logic [1:0] alt,
                                    input logic t12, input logic trtc, input logic tcmp);
    if (fast) begin
      return 1'b1;
    end
    unique case (alt)
      2'h0: return t12;
      2'h1: return trtc;
      2'h3: return tcmp;
      default: return 1'b0; // reserved code stops the byte
    endcase
  endfunction

  logic [3:0] div_cnt, next_div_cnt;
  logic [2:0] rtc_cnt, next_rtc_cnt;
  logic       rtc_s1, rtc_s2, rtc_s3, cmp_s1, cmp_s2, cmp_s3;
  logic       tick12, tick_rtc, tick_cmp;

  // source dividers and edge detectors; first sync stage feeds only the second
  always_comb begin
    tick12       = (div_cnt == 4'(SYS_DIV - 1));
    next_div_cnt = tick12 ? 4'h0 : div_cnt + 4'h1;
    tick_rtc     = rtc_s2 & ~rtc_s3 & (rtc_cnt == 3'(RTC_DIV - 1)); // [RL8]
    next_rtc_cnt = (rtc_s2 & ~rtc_s3) ? rtc_cnt + 3'h1 : rtc_cnt;
    tick_cmp     = cmp_s2 & ~cmp_s3; // [RL8]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt <= 4'h0;
      rtc_cnt <= 3'h0;
      rtc_s1  <= 1'b0;
      rtc_s2  <= 1'b0;
      rtc_s3  <= 1'b0;
      cmp_s1  <= 1'b0;
      cmp_s2  <= 1'b0;
      cmp_s3  <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      rtc_cnt <= next_rtc_cnt;
      rtc_s1  <= rtc_clk;
      rtc_s2  <= rtc_s1;
      rtc_s3  <= rtc_s2;
      cmp_s1  <= cmp0_out;
      cmp_s2  <= cmp_s1;
      cmp_s3  <= cmp_s2;
    end
  end

  t2rc_ctrl_t ctrl, next_ctrl;
  logic [7:0] count_low_byte, count_high_byte, reload_low_byte, reload_high_byte;
  logic [7:0] next_cl, next_ch, next_rl, next_rh, next_rdata, ctrl_wval;
  logic       next_irq, tick_lo, tick_hi, inc_lo, inc_hi, wrap_lo, wrap_hi, cap_evt;
  logic       wr_ctrl, wr_cl, wr_ch;

  // counting, reload, capture and the register port
  always_comb begin
    wr_ctrl = (sfr_req.wr | sfr_req.bit_wr) && sfr_req.addr == `T2RC_ADDR_CTRL;
    wr_cl   = sfr_req.wr && sfr_req.addr == `T2RC_ADDR_CNT_LO;
    wr_ch   = sfr_req.wr && sfr_req.addr == `T2RC_ADDR_CNT_HI;
    tick_lo = src_tick(low_byte_fast_clock_sel, ctrl.alt_clock_field, tick12, tick_rtc, tick_cmp);  // [RL7]
    tick_hi = src_tick(high_byte_fast_clock_sel, ctrl.alt_clock_field, tick12, tick_rtc, tick_cmp); // [RL7]
    if (ctrl.split_mode_select) begin
      inc_lo = tick_lo;                         // [RL6] low byte free-running
      inc_hi = tick_hi & ctrl.run_control_bit;  // [RL6]
    end else begin
      inc_lo = tick_lo & ctrl.run_control_bit;  // [RL1] [RL19]
      inc_hi = inc_lo && count_low_byte == `T2RC_BYTE_MAX;
    end
    wrap_lo = inc_lo && count_low_byte == `T2RC_BYTE_MAX;
    wrap_hi = inc_hi && count_high_byte == `T2RC_BYTE_MAX;
    // capture source bit clear picks rtc/8, set picks the comparator edge
    cap_evt = ctrl.capture_mode_enable & (ctrl.alt_clock_field[1] ? tick_cmp : tick_rtc); // [RL12] [RL14] [RL18]
    // count bytes; a software write beats the increment in the same cycle
    next_cl = count_low_byte;
    next_ch = count_high_byte;
    if (inc_lo) begin
      if (ctrl.split_mode_select) begin
        next_cl = wrap_lo ? reload_low_byte : count_low_byte + 8'h01; // [RL5]
      end else begin
        next_cl = (wrap_lo && wrap_hi) ? reload_low_byte : count_low_byte + 8'h01; // [RL2]
      end
    end
    if (inc_hi) begin
      next_ch = wrap_hi ? reload_high_byte : count_high_byte + 8'h01; // [RL2] [RL5]
    end
    if (wr_cl) begin
      next_cl = sfr_req.wdata;
    end
    if (wr_ch) begin
      next_ch = sfr_req.wdata;
    end
    // reload pair; capture beats a software write
    next_rl = (sfr_req.wr && sfr_req.addr == `T2RC_ADDR_RLD_LO) ? sfr_req.wdata : reload_low_byte;
    next_rh = (sfr_req.wr && sfr_req.addr == `T2RC_ADDR_RLD_HI) ? sfr_req.wdata : reload_high_byte;
    if (cap_evt) begin
      next_rl = count_low_byte;  // [RL15]
      next_rh = count_high_byte; // [RL15]
    end
    // control: whole-byte or single-bit write, then hardware sets win over clears
    ctrl_wval = sfr_req.bit_wr ? ctrl : sfr_req.wdata;
    if (sfr_req.bit_wr) begin
      ctrl_wval[sfr_req.bit_sel] = sfr_req.wdata[0]; // [RL16]
    end
    next_ctrl = wr_ctrl ? t2rc_ctrl_t'(ctrl_wval) : ctrl;
    next_ctrl.high_overflow_flag = next_ctrl.high_overflow_flag | wrap_hi | cap_evt; // [RL9] [RL11] [RL15]
    next_ctrl.low_overflow_flag  = next_ctrl.low_overflow_flag | wrap_lo;            // [RL9] [RL11] [RL17]
    // level request; the low flag only counts with its own enable
    next_irq = timer_irq_enable & (ctrl.high_overflow_flag
               | (ctrl.low_overflow_irq_enable & ctrl.low_overflow_flag)); // [RL3] [RL4] [RL10]
    unique case (sfr_req.addr)
      `T2RC_ADDR_CTRL:   next_rdata = ctrl;
      `T2RC_ADDR_RLD_LO: next_rdata = reload_low_byte;
      `T2RC_ADDR_RLD_HI: next_rdata = reload_high_byte;
      `T2RC_ADDR_CNT_LO: next_rdata = count_low_byte;
      `T2RC_ADDR_CNT_HI: next_rdata = count_high_byte;
      default:           next_rdata = 8'h00; // other sfrs answer zero from this block
    endcase
    if (!sfr_req.rd) begin
      next_rdata = sfr_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl             <= t2rc_ctrl_t'(`T2RC_CTRL_RESET); // [RL16]
      count_low_byte   <= 8'h00;
      count_high_byte  <= 8'h00;
      reload_low_byte  <= 8'h00;
      reload_high_byte <= 8'h00;
      sfr_rdata        <= 8'h00;
      irq_request      <= 1'b0;
    end else begin
      ctrl             <= next_ctrl;
      count_low_byte   <= next_cl;
      count_high_byte  <= next_ch;
      reload_low_byte  <= next_rl;
      reload_high_byte <= next_rh;
      sfr_rdata        <= next_rdata;
      irq_request      <= next_irq;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic quiet;
  assign quiet = !sfr_req.wr && !sfr_req.bit_wr;

  a_wrap_reload_pair: assert property (!ctrl.split_mode_select && inc_lo && count_low_byte == 8'hFF // [RL2]
      && count_high_byte == 8'hFF && quiet && !cap_evt
      |=> {count_high_byte, count_low_byte} == {$past(reload_high_byte), $past(reload_low_byte)}
          && ctrl.high_overflow_flag && ctrl.low_overflow_flag)
    else $error("16-bit wrap did not reload and flag");
  a_low_flag_any: assert property (inc_lo && count_low_byte == 8'hFF && quiet |=> ctrl.low_overflow_flag) // [RL17]
    else $error("low wrap did not set low flag");
  a_split_low_free: assert property (ctrl.split_mode_select && !ctrl.run_control_bit && tick_lo // [RL6]
      && count_low_byte != 8'hFF && quiet |=> count_low_byte == $past(count_low_byte) + 8'h01)
    else $error("split low byte did not count with run clear");
  a_split_high_gate: assert property (ctrl.split_mode_select && !ctrl.run_control_bit && quiet // [RL6]
      |=> count_high_byte == $past(count_high_byte))
    else $error("split high byte moved with run clear");
  a_mode16_run_gate: assert property (!ctrl.split_mode_select && !ctrl.run_control_bit && quiet // [RL19]
      |=> $stable({count_high_byte, count_low_byte}))
    else $error("16-bit counter moved with run clear");
  a_capture_copy: assert property (cap_evt |=> {reload_high_byte, reload_low_byte} // [RL15]
      == {$past(count_high_byte), $past(count_low_byte)} && ctrl.high_overflow_flag)
    else $error("capture did not copy count");
  a_flag_sticky: assert property (ctrl.high_overflow_flag && ctrl.low_overflow_flag && quiet // [RL11]
      |=> ctrl.high_overflow_flag && ctrl.low_overflow_flag)
    else $error("hardware cleared an overflow flag");
  a_irq_follow: assert property (timer_irq_enable && ctrl.high_overflow_flag |=> irq_request) // [RL3]
    else $error("high flag did not raise interrupt");
  a_irq_low_mask: assert property (!ctrl.high_overflow_flag && !ctrl.low_overflow_irq_enable // [RL4]
      |=> !irq_request)
    else $error("low flag raised interrupt while disabled");
  a_div12_spacing: assert property (tick12 |=> !tick12 [*8]) // [RL7]
    else $error("divide-by-12 tick too close");
  // per-byte reload, capture gating, clock source decode and the low-byte interrupt path
  a_split_low_reload: assert property (ctrl.split_mode_select && inc_lo && count_low_byte == 8'hFF // [RL5]
      && quiet |=> count_low_byte == $past(reload_low_byte))
    else $error("split low byte did not reload");
  a_split_high_reload: assert property (ctrl.split_mode_select && inc_hi // [RL5] [RL9]
      && count_high_byte == 8'hFF && quiet |=> count_high_byte == $past(reload_high_byte) && ctrl.high_overflow_flag)
    else $error("split high byte did not reload and flag");
  a_capture_gate: assert property (!ctrl.capture_mode_enable && quiet // [RL12]
      |=> $stable({reload_high_byte, reload_low_byte}))
    else $error("reload pair moved with capture off");
  a_reserved_stop: assert property (!low_byte_fast_clock_sel && ctrl.alt_clock_field == 2'h2 && quiet // [RL7]
      |=> $stable(count_low_byte))
    else $error("reserved clock code moved the low byte");
  a_cmp_source: assert property (!low_byte_fast_clock_sel && ctrl.alt_clock_field == 2'h3 // [RL7] [RL8]
      && !ctrl.split_mode_select && ctrl.run_control_bit && tick_cmp && count_low_byte != 8'hFF && quiet
      |=> count_low_byte == $past(count_low_byte) + 8'h01)
    else $error("comparator edge did not advance the counter");
  a_low_irq: assert property (timer_irq_enable && ctrl.low_overflow_irq_enable && ctrl.low_overflow_flag // [RL4] [RL10]
      |=> irq_request)
    else $error("enabled low flag did not raise interrupt");

  c_wrap_16: cover property (!ctrl.split_mode_select && wrap_hi);
  c_split_low_wrap: cover property (ctrl.split_mode_select && wrap_lo && !ctrl.run_control_bit);
  c_capture_cmp: cover property (cap_evt && ctrl.alt_clock_field[1]);
  c_capture_rtc: cover property (cap_evt && !ctrl.alt_clock_field[1]);
  // split high byte wrap only happens with the run bit set
  c_split_high_wrap: cover property (ctrl.split_mode_select && wrap_hi);
endmodule

// ### sim/timer2_reload_capture_tb.sv
// self-checking bench for the reload/capture timer: register port, 16-bit and split modes, capture
// assumes the package and t2rc_timer under logic/ are compiled first and the include path holds logic/
`timescale 1ns/100ps
`include "t2rc_consts.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module timer2_reload_capture_tb import t2rc_pkg::*; ;
  logic          sys_clk, rst, lfast, hfast, irq_en, rtc_clk, cmp0, irq;
  t2rc_sfr_req_t req;
  logic [7:0]    rdata, r;
  int            failures, checks_done;
  logic [7:0]    expq[$];
  string         nameq[$];

  t2rc_timer dut (.sys_clk(sys_clk), .rst(rst), .sfr_req(req), .low_byte_fast_clock_sel(lfast),
    .high_byte_fast_clock_sel(hfast), .timer_irq_enable(irq_en), .rtc_clk(rtc_clk), .cmp0_out(cmp0),
    .sfr_rdata(rdata), .irq_request(irq));

  // 50 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // one access pulse, launched on a falling edge so the rising edge sees it settled
  task automatic acc(input logic w, input logic b, input logic rr, input logic [7:0] a,
                     input logic [2:0] s, input logic [7:0] d);
    @(negedge sys_clk);
    req <= '{wr: w, rd: rr, bit_wr: b, addr: a, bit_sel: s, wdata: d};
    @(negedge sys_clk);
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, 1'b0, a, 3'h0, d);
  endtask
  task automatic bw(input logic [2:0] s, input logic v);
    acc(1'b0, 1'b1, 1'b0, 8'hC8, s, {7'h00, v});
  endtask
  // the expectation is queued before the strobe so the monitor always finds it
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    nameq.push_back(n);
    acc(1'b0, 1'b0, 1'b1, a, 3'h0, 8'h00);
  endtask
  // bounded wait on the interrupt level
  task automatic wirq(input logic e);
    for (int i = 0; i < 40 && irq !== e; i++) @(negedge sys_clk);
    `CHK("irq_request", e, irq)
  endtask
  task automatic rtc_pulse();
    repeat (3) @(negedge sys_clk);
    rtc_clk = 1'b1;
    repeat (3) @(negedge sys_clk);
    rtc_clk = 1'b0;
  endtask

  // read data lands on the edge that samples the strobe; the monitor looks 1 ns after it
  always @(posedge sys_clk) begin : mon_blk
    logic [7:0] e;
    string      n;
    if (req.rd === 1'b1) begin
      #1;
      e = expq.pop_front();
      n = nameq.pop_front();
      `CHK(n, e, rdata)
    end
  end

  task automatic results();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the roughly 450 cycles the sequence needs
  initial begin
    #400000;
    failures++;
    results();
  end

  initial begin
    {rst, lfast, hfast, irq_en, rtc_clk, cmp0} = 6'b111100;
    req = '0;
    failures = 0;
    checks_done = 0;
    r = 8'($urandom(32'h6134));
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    rd("ctrl", 8'hC8, 8'h00);
    rd("unmapped", 8'hC9, 8'h00);
    wr(8'hC8, 8'h03);
    bw(3'h5, 1'b1);
    rd("ctrl", 8'hC8, 8'h23);
    wr(8'hC8, 8'h00);
    // 16-bit wrap from all ones with a random reload high byte
    r = 8'($urandom);
    wr(8'hCA, 8'h10);
    wr(8'hCB, r);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    repeat (5) @(negedge sys_clk);
    rd("cnt_hi", 8'hCD, 8'hFF);
    bw(3'h2, 1'b1);
    wirq(1'b1);
    bw(3'h2, 1'b0);
    rd("ctrl", 8'hC8, 8'hC0);
    rd("cnt_hi", 8'hCD, r);
    repeat (10) @(negedge sys_clk);
    rd("ctrl", 8'hC8, 8'hC0);
    wr(8'hC8, 8'h00);
    wirq(1'b0);
    // low-byte wrap inside 16-bit mode, first without its enable
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'h12);
    bw(3'h2, 1'b1);
    repeat (10) @(negedge sys_clk);
    `CHK("irq_request", 1'b0, irq)
    bw(3'h2, 1'b0);
    rd("ctrl", 8'hC8, 8'h40);
    rd("cnt_hi", 8'hCD, 8'h13);
    bw(3'h5, 1'b1);
    wirq(1'b1);
    // split mode: low byte runs with the run bit clear
    // top bit cleared: the high byte counts three more edges after its wrap and must not wrap again
    r = 8'($urandom) & 8'h7F;
    wr(8'hC8, 8'h08);
    wr(8'hCD, 8'h55);
    wr(8'hCC, 8'hFE);
    repeat (6) @(negedge sys_clk);
    rd("cnt_hi", 8'hCD, 8'h55);
    rd("ctrl", 8'hC8, 8'h48);
    `CHK("irq_request", 1'b0, irq)
    bw(3'h5, 1'b1);
    wirq(1'b1);
    wr(8'hC8, 8'h08);
    wr(8'hCB, r);
    wr(8'hCD, 8'hFF);
    bw(3'h2, 1'b1);
    wirq(1'b1);
    bw(3'h2, 1'b0);
    rd("cnt_hi", 8'hCD, r + 8'h03);
    // comparator capture on a frozen count, so the captured value is exact
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h56);
    wr(8'hCD, 8'h34);
    wr(8'hC8, 8'h13); // split kept clear while capturing
    cmp0 = 1'b1;
    repeat (8) @(negedge sys_clk);
    rd("rld_lo", 8'hCA, 8'h56);
    rd("rld_hi", 8'hCB, 8'h34);
    rd("ctrl", 8'hC8, 8'h93);
    rd("cnt_lo", 8'hCC, 8'h56);
    wirq(1'b1);
    cmp0 = 1'b0;
    // real-time-clock capture fires on the eighth edge only
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h9A);
    wr(8'hCD, 8'h78);
    wr(8'hC8, 8'h11); // split kept clear while capturing
    repeat (7) rtc_pulse();
    repeat (8) @(negedge sys_clk);
    rd("rld_lo", 8'hCA, 8'h56);
    rtc_pulse();
    repeat (8) @(negedge sys_clk);
    rd("rld_lo", 8'hCA, 8'h9A);
    rd("rld_hi", 8'hCB, 8'h78);
    // capture disabled: a comparator edge leaves the reload pair alone
    wr(8'hC8, 8'h03);
    wr(8'hCC, 8'h01);
    cmp0 = 1'b1;
    repeat (8) @(negedge sys_clk);
    rd("rld_lo", 8'hCA, 8'h9A);
    // count sources with the fast select off: divide-by-12 first
    lfast = 1'b0;
    cmp0 = 1'b0;
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h00);
    bw(3'h2, 1'b1);
    repeat (118) @(negedge sys_clk); // 120 counting edges hold exactly ten ticks
    bw(3'h2, 1'b0);
    rd("cnt_lo", 8'hCC, 8'h0A);
    // comparator edges as the count clock
    wr(8'hC8, 8'h07);
    wr(8'hCC, 8'h00);
    repeat (3) begin
      repeat (3) @(negedge sys_clk);
      cmp0 = 1'b1;
      repeat (3) @(negedge sys_clk);
      cmp0 = 1'b0;
    end
    repeat (6) @(negedge sys_clk);
    rd("cnt_lo", 8'hCC, 8'h03);
    // reserved code: neither edges nor divided ticks move the count
    wr(8'hC8, 8'h06);
    cmp0 = 1'b1;
    repeat (30) @(negedge sys_clk);
    rd("cnt_lo", 8'hCC, 8'h03);
    cmp0 = 1'b0;
    lfast = 1'b1;
    // cpu enable low masks a set flag
    irq_en = 1'b0;
    wr(8'hC8, 8'h80);
    repeat (4) @(negedge sys_clk);
    `CHK("irq_request", 1'b0, irq)
    irq_en = 1'b1;
    wirq(1'b1);
    results();
  end
endmodule
